// >>> core/smcr_regs.sv
// Synthesizer and modulator control register bank with decoded controls.
// Assumes a serial front end on CLK_I delivering byte writes and reads;
// reference, feedback and transmit-off pins are asynchronous to CLK_I.
//
// Overview of operation
// - Buffered fields commit on offset-zero write
// - Integer word twelve bits across two registers
// - Test output select drives pin per code
// - Charge pump current code, sixteen steps
// - Reference halving stage inserted when set
// - Reference doubler enabled when set
// - Reference divider code zero divides thirty-two
// - PLL power-down bit two
// - Attenuator, buffer, quad divider gated by transmit-off
// - Doubler stage and RF monitor gated similarly
// - Lock detector enable bit
// - Lock count 3072 or 2048 pulses
// - Lock window coarse or fine
// - Autocalibration disable bit
// - External oscillator select bit
// - Oscillator monitor power-up bit
// - Monitor output level code
// - Internal oscillator power-down bit
// - Modulator power-up bit
// - Attenuation code to dB mapping
// - Revision register read-only
// - Offset-zero write starts new acquisition
`timescale 1ns/1ps
`default_nettype none
`include "smcr_defines.svh"

module smcr_regs #(
  parameter logic [7:0] REVISION_CODE = 8'h5a  // Arbitrary value
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire smcr_pkg::smcr_addr_t REG_ADDR_I,
  input wire smcr_pkg::smcr_byte_t REG_WDATA_I,
  output smcr_pkg::smcr_byte_t REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic TRANSMIT_OFF_PIN_I,
  input wire logic REF_CLK_I,
  input wire logic FEEDBACK_COMPARE_CLOCK_I,
  input wire logic LOCK_CMP_PULSE_I,
  input wire logic LOCK_IN_WINDOW_I,
  output logic [11:0] INT_WORD_O,
  output logic [3:0] CP_CURRENT_O,
  output logic REF_HALF_EN_O,
  output logic REF_DOUBLE_EN_O,
  output logic [5:0] REF_DIV_RATIO_O,
  output logic ACQ_START_O,
  output logic TEST_OUT_O,
  output logic TEST_OUT_OE_N_O,
  output logic PLL_POWER_DOWN_O,
  output logic ATTEN_EN_O,
  output logic OSC_BUFFER_EN_O,
  output logic QUADRATURE_DIVIDER_EN_O,
  output logic OSC_FREQ_DOUBLER_EN_O,
  output logic RF_OUTPUT_MONITOR_EN_O,
  output logic LOCK_FINE_WINDOW_O,
  output logic LOCK_DETECT_O,
  output logic AUTOCAL_EN_O,
  output logic EXT_OSC_SEL_O,
  output logic MON_POWER_UP_O,
  output logic [1:0] MON_LEVEL_O,
  output logic INT_OSC_POWER_DOWN_O,
  output logic MODULATOR_POWER_UP_O,
  output logic [5:0] ATTEN_DB_O
);
  import smcr_pkg::*;

  function automatic logic wr_hit(input logic wr, input smcr_addr_t a, input smcr_addr_t off);
    wr_hit = wr && (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a level counts once stages two and three agree

  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_level;
  assign pin_raw = {FEEDBACK_COMPARE_CLOCK_I, REF_CLK_I, TRANSMIT_OFF_PIN_I};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic lvl_reg;
      always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          lvl_reg <= 1'b0;
        end else begin
          s1_reg <= pin_raw[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            lvl_reg <= s3_reg;
          end
        end
      end
      assign pin_level[gi] = lvl_reg;
    end
  endgenerate

  logic tx_off;
  assign tx_off = pin_level[0];

  //////////////////////////////////////////////////////////////////////////////
  // Shadow copies, written directly by the host

  logic commit;
  assign commit = wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_COMMIT);

  smcr_byte_t int_lo_sh_reg;
  logic [3:0] int_hi_sh_reg;
  logic [3:0] cp_sh_reg;
  logic ref_half_sh_reg;
  logic ref_double_sh_reg;
  logic [4:0] rdiv_sh_reg;

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      int_lo_sh_reg <= `SMCR_RST_BYTE;
      int_hi_sh_reg <= `SMCR_RST_INT_HI;
      cp_sh_reg <= `SMCR_RST_CP;
      ref_half_sh_reg <= 1'b0;
      ref_double_sh_reg <= 1'b0;
      rdiv_sh_reg <= `SMCR_RST_RDIV;
    end else begin
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_INT_LO)) begin
        int_lo_sh_reg <= REG_WDATA_I;
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_INT_HI_TEST)) begin
        int_hi_sh_reg <= REG_WDATA_I[3:0];
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_CP_CURRENT)) begin
        cp_sh_reg <= REG_WDATA_I[7:4];
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_REF_PATH)) begin
        ref_half_sh_reg <= REG_WDATA_I[`SMCR_BIT_REF_HALF];
        ref_double_sh_reg <= REG_WDATA_I[`SMCR_BIT_REF_DOUBLE];
        rdiv_sh_reg <= REG_WDATA_I[4:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Active configuration, loaded only by the commit write

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      INT_WORD_O <= 12'h000;
      CP_CURRENT_O <= `SMCR_RST_CP;
      REF_HALF_EN_O <= 1'b0;
      REF_DOUBLE_EN_O <= 1'b0;
      REF_DIV_RATIO_O <= `SMCR_RDIV_ZERO_RATIO;
    end else if (commit) begin
      INT_WORD_O <= {int_hi_sh_reg, int_lo_sh_reg};
      CP_CURRENT_O <= cp_sh_reg;
      REF_HALF_EN_O <= ref_half_sh_reg;
      REF_DOUBLE_EN_O <= ref_double_sh_reg;
      REF_DIV_RATIO_O <= (rdiv_sh_reg == 5'h00) ? `SMCR_RDIV_ZERO_RATIO
                                                : {1'b0, rdiv_sh_reg};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ACQ_START_O <= 1'b0;
    end else begin
      ACQ_START_O <= commit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Unbuffered fields act on their own write

  logic [3:0] test_sel_reg;
  logic pll_pd_reg;
  logic [4:0] gate_reg;
  logic lock_en_reg;
  logic lock_short_reg;
  logic lock_fine_reg;
  logic autocal_off_reg;
  logic ext_osc_reg;
  logic mon_pwr_reg;
  logic [1:0] mon_lvl_reg;
  logic osc_pd_reg;
  logic mod_pwr_reg;
  logic [5:0] atten_reg;

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      test_sel_reg <= `SMCR_RST_TEST;
      pll_pd_reg <= 1'b0;
      gate_reg <= 5'h00;
      lock_en_reg <= 1'b0;
      lock_short_reg <= 1'b0;
      lock_fine_reg <= 1'b0;
      autocal_off_reg <= 1'b0;
      ext_osc_reg <= 1'b0;
      mon_pwr_reg <= 1'b0;
      mon_lvl_reg <= `SMCR_RST_MON_LVL;
      osc_pd_reg <= 1'b0;
      mod_pwr_reg <= 1'b0;
      atten_reg <= `SMCR_RST_ATTEN;
    end else begin
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_INT_HI_TEST)) begin
        test_sel_reg <= REG_WDATA_I[7:4];
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_PLL_POWER)) begin
        pll_pd_reg <= REG_WDATA_I[`SMCR_BIT_PLL_PD];
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_TX_GATE)) begin
        gate_reg <= {REG_WDATA_I[`SMCR_BIT_GATE_ATTEN], REG_WDATA_I[`SMCR_BIT_GATE_OSC_BUF],
                     REG_WDATA_I[`SMCR_BIT_GATE_QUAD_DIV], REG_WDATA_I[`SMCR_BIT_GATE_DOUBLER],
                     REG_WDATA_I[`SMCR_BIT_GATE_RF_MON]};
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_LOCK_CTRL)) begin
        lock_en_reg <= REG_WDATA_I[`SMCR_BIT_LOCK_EN];
        lock_short_reg <= REG_WDATA_I[`SMCR_BIT_LOCK_SHORT];
        lock_fine_reg <= REG_WDATA_I[`SMCR_BIT_LOCK_FINE];
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_AUTOCAL)) begin
        autocal_off_reg <= REG_WDATA_I[`SMCR_BIT_AUTOCAL_OFF];
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_OSC_MON)) begin
        ext_osc_reg <= REG_WDATA_I[`SMCR_BIT_EXT_OSC];
        mon_pwr_reg <= REG_WDATA_I[`SMCR_BIT_MON_PWR];
        mon_lvl_reg <= REG_WDATA_I[1:0];
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_OSC_POWER)) begin
        osc_pd_reg <= REG_WDATA_I[`SMCR_BIT_OSC_PD];
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_MOD_POWER)) begin
        mod_pwr_reg <= REG_WDATA_I[`SMCR_BIT_MOD_PWR];
      end
      if (wr_hit(REG_WR_I, REG_ADDR_I, `SMCR_OFF_ATTEN)) begin
        atten_reg <= REG_WDATA_I[5:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded controls; the gates follow the synchronised transmit-off level

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      PLL_POWER_DOWN_O <= 1'b0;
      ATTEN_EN_O <= 1'b1;
      OSC_BUFFER_EN_O <= 1'b1;
      QUADRATURE_DIVIDER_EN_O <= 1'b1;
      OSC_FREQ_DOUBLER_EN_O <= 1'b1;
      RF_OUTPUT_MONITOR_EN_O <= 1'b1;
      LOCK_FINE_WINDOW_O <= 1'b0;
      AUTOCAL_EN_O <= 1'b1;
      EXT_OSC_SEL_O <= 1'b0;
      MON_POWER_UP_O <= 1'b0;
      MON_LEVEL_O <= `SMCR_RST_MON_LVL;
      INT_OSC_POWER_DOWN_O <= 1'b0;
      MODULATOR_POWER_UP_O <= 1'b0;
      ATTEN_DB_O <= `SMCR_RST_ATTEN;
    end else begin
      PLL_POWER_DOWN_O <= pll_pd_reg;
      ATTEN_EN_O <= !(gate_reg[4] && tx_off);
      OSC_BUFFER_EN_O <= !(gate_reg[3] && tx_off);
      QUADRATURE_DIVIDER_EN_O <= !(gate_reg[2] && tx_off);
      OSC_FREQ_DOUBLER_EN_O <= !(gate_reg[1] && tx_off);
      RF_OUTPUT_MONITOR_EN_O <= !(gate_reg[0] && tx_off);
      LOCK_FINE_WINDOW_O <= lock_fine_reg;
      AUTOCAL_EN_O <= !autocal_off_reg;
      EXT_OSC_SEL_O <= ext_osc_reg;
      MON_POWER_UP_O <= mon_pwr_reg;
      MON_LEVEL_O <= mon_lvl_reg;
      INT_OSC_POWER_DOWN_O <= osc_pd_reg;
      MODULATOR_POWER_UP_O <= mod_pwr_reg;
      // Codes between the two documented ranges have no defined step; hold 31 dB
      if (atten_reg <= `SMCR_ATTEN_LOW_MAX) begin
        ATTEN_DB_O <= atten_reg;
      end else if (atten_reg >= `SMCR_ATTEN_HIGH_MIN) begin
        ATTEN_DB_O <= atten_reg - `SMCR_ATTEN_HIGH_OFFSET;
      end else begin
        ATTEN_DB_O <= `SMCR_ATTEN_LOW_MAX;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Test output pin: halved clocks toggle on each synchronised rising edge

  logic ref_prev_reg;
  logic fb_prev_reg;
  logic ref_half_reg;
  logic fb_half_reg;

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ref_prev_reg <= 1'b0;
      fb_prev_reg <= 1'b0;
      ref_half_reg <= 1'b0;
      fb_half_reg <= 1'b0;
    end else begin
      ref_prev_reg <= pin_level[1];
      fb_prev_reg <= pin_level[2];
      if (pin_level[1] && !ref_prev_reg) begin
        ref_half_reg <= !ref_half_reg;
      end
      if (pin_level[2] && !fb_prev_reg) begin
        fb_half_reg <= !fb_half_reg;
      end
    end
  end

  // Undefined select codes leave the pin undriven, the safe choice on a shared net
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      TEST_OUT_O <= 1'b0;
      TEST_OUT_OE_N_O <= 1'b1;
    end else begin
      unique case (test_sel_reg)
        `SMCR_TEST_HIGH: begin
          TEST_OUT_O <= 1'b1;
          TEST_OUT_OE_N_O <= 1'b0;
        end
        `SMCR_TEST_LOW: begin
          TEST_OUT_O <= 1'b0;
          TEST_OUT_OE_N_O <= 1'b0;
        end
        `SMCR_TEST_REF_HALF: begin
          TEST_OUT_O <= ref_half_reg;
          TEST_OUT_OE_N_O <= 1'b0;
        end
        `SMCR_TEST_FB_HALF: begin
          TEST_OUT_O <= fb_half_reg;
          TEST_OUT_OE_N_O <= 1'b0;
        end
        default: begin
          TEST_OUT_O <= 1'b0;
          TEST_OUT_OE_N_O <= 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lock detector: consecutive in-window comparisons; a miss or new acquisition restarts

  smcr_lock_e ld_state_reg;
  smcr_lock_cnt_t ld_cnt_reg;
  smcr_lock_cnt_t ld_target;
  assign ld_target = lock_short_reg ? `SMCR_LOCK_CNT_SHORT : `SMCR_LOCK_CNT_LONG;

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      ld_state_reg <= SMCR_LD_OFF;
      ld_cnt_reg <= '0;
    end else if (!lock_en_reg || pll_pd_reg || commit) begin
      ld_state_reg <= lock_en_reg ? SMCR_LD_COUNT : SMCR_LD_OFF;
      ld_cnt_reg <= '0;
    end else begin
      unique case (ld_state_reg)
        SMCR_LD_OFF: begin
          ld_state_reg <= SMCR_LD_COUNT;
        end
        SMCR_LD_COUNT: begin
          if (LOCK_CMP_PULSE_I) begin
            if (!LOCK_IN_WINDOW_I) begin
              ld_cnt_reg <= '0;
            end else if (ld_cnt_reg + 1'b1 >= ld_target) begin
              ld_state_reg <= SMCR_LD_LOCKED;
            end else begin
              ld_cnt_reg <= ld_cnt_reg + 1'b1;
            end
          end
        end
        SMCR_LD_LOCKED: begin
          if (LOCK_CMP_PULSE_I && !LOCK_IN_WINDOW_I) begin
            ld_state_reg <= SMCR_LD_COUNT;
            ld_cnt_reg <= '0;
          end
        end
      endcase
    end
  end

  assign LOCK_DETECT_O = (ld_state_reg == SMCR_LD_LOCKED);

  //////////////////////////////////////////////////////////////////////////////
  // Read-back: shadow values as written; reserved bits and unmapped offsets read zero

  smcr_byte_t rd_next;
  always_comb begin
    rd_next = 8'h00;
    unique case (REG_ADDR_I)
      `SMCR_OFF_INT_LO: rd_next = int_lo_sh_reg;
      `SMCR_OFF_INT_HI_TEST: rd_next = {test_sel_reg, int_hi_sh_reg};
      `SMCR_OFF_CP_CURRENT: rd_next = {cp_sh_reg, 4'h0};
      `SMCR_OFF_REF_PATH: rd_next = {1'b0, ref_half_sh_reg, ref_double_sh_reg, rdiv_sh_reg};
      `SMCR_OFF_PLL_POWER: rd_next[`SMCR_BIT_PLL_PD] = pll_pd_reg;
      `SMCR_OFF_TX_GATE: rd_next = {2'h0, gate_reg[4:2], 1'b0, gate_reg[1:0]};
      `SMCR_OFF_LOCK_CTRL: rd_next = {3'h0, lock_en_reg, lock_short_reg, lock_fine_reg, 2'h0};
      `SMCR_OFF_AUTOCAL: rd_next[`SMCR_BIT_AUTOCAL_OFF] = autocal_off_reg;
      `SMCR_OFF_OSC_MON: rd_next = {4'h0, ext_osc_reg, mon_pwr_reg, mon_lvl_reg};
      `SMCR_OFF_OSC_POWER: rd_next[`SMCR_BIT_OSC_PD] = osc_pd_reg;
      `SMCR_OFF_MOD_POWER: rd_next[`SMCR_BIT_MOD_PWR] = mod_pwr_reg;
      `SMCR_OFF_ATTEN: rd_next = {2'h0, atten_reg};
      `SMCR_OFF_REVISION: rd_next = REVISION_CODE;
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      REG_RDATA_O <= 8'h00;
      REG_RVALID_O <= 1'b0;
    end else begin
      REG_RVALID_O <= REG_RD_I;
      if (REG_RD_I) begin
        REG_RDATA_O <= rd_next;
      end
    end
  end

endmodule // smcr_regs
`default_nettype wire

// >>> pkg/smcr_defines.svh
// Offsets, field positions, reset values and counts for the synthesizer
// control register bank. Assumes a 6-bit byte address from the serial front end.
`ifndef SMCR_DEFINES_SVH
`define SMCR_DEFINES_SVH

`define SMCR_ADDR_W 6
`define SMCR_OFF_COMMIT 6'h00
`define SMCR_OFF_INT_LO 6'h06
`define SMCR_OFF_INT_HI_TEST 6'h07
`define SMCR_OFF_CP_CURRENT 6'h09
`define SMCR_OFF_REF_PATH 6'h0a
`define SMCR_OFF_PLL_POWER 6'h0c
`define SMCR_OFF_TX_GATE 6'h0e
`define SMCR_OFF_LOCK_CTRL 6'h17
`define SMCR_OFF_AUTOCAL 6'h18
`define SMCR_OFF_OSC_MON 6'h1b
`define SMCR_OFF_OSC_POWER 6'h1c
`define SMCR_OFF_MOD_POWER 6'h1d
`define SMCR_OFF_ATTEN 6'h1e
`define SMCR_OFF_REVISION 6'h21

`define SMCR_BIT_PLL_PD 2
`define SMCR_BIT_GATE_ATTEN 5
`define SMCR_BIT_GATE_OSC_BUF 4
`define SMCR_BIT_GATE_QUAD_DIV 3
`define SMCR_BIT_GATE_DOUBLER 1
`define SMCR_BIT_GATE_RF_MON 0
`define SMCR_BIT_LOCK_EN 4
`define SMCR_BIT_LOCK_SHORT 3
`define SMCR_BIT_LOCK_FINE 2
`define SMCR_BIT_AUTOCAL_OFF 0
`define SMCR_BIT_EXT_OSC 3
`define SMCR_BIT_MON_PWR 2
`define SMCR_BIT_OSC_PD 5
`define SMCR_BIT_MOD_PWR 0
`define SMCR_BIT_REF_HALF 6
`define SMCR_BIT_REF_DOUBLE 5

`define SMCR_RST_BYTE 8'h00
`define SMCR_RST_INT_HI 4'h0
`define SMCR_RST_TEST 4'h0
`define SMCR_RST_CP 4'h0
`define SMCR_RST_RDIV 5'h00
`define SMCR_RST_ATTEN 6'h00
`define SMCR_RST_MON_LVL 2'h0

`define SMCR_TEST_TRISTATE 4'h0
`define SMCR_TEST_HIGH 4'h1
`define SMCR_TEST_LOW 4'h2
`define SMCR_TEST_REF_HALF 4'hd
`define SMCR_TEST_FB_HALF 4'he

`define SMCR_RDIV_ZERO_RATIO 6'h20
`define SMCR_ATTEN_LOW_MAX 6'h1f
`define SMCR_ATTEN_HIGH_MIN 6'h30
`define SMCR_ATTEN_HIGH_OFFSET 6'h10

`define SMCR_LOCK_CNT_W 12
`define SMCR_LOCK_CNT_LONG 12'hc00
`define SMCR_LOCK_CNT_SHORT 12'h800

`endif

// >>> pkg/smcr_pkg.sv
// Types shared by the synthesizer control register bank.
// Assumes smcr_defines.svh is on the include path.
`include "smcr_defines.svh"

package smcr_pkg;
  typedef logic [`SMCR_ADDR_W-1:0] smcr_addr_t;
  typedef logic [7:0] smcr_byte_t;
  typedef logic [`SMCR_LOCK_CNT_W-1:0] smcr_lock_cnt_t;
  typedef enum logic [1:0] {
    SMCR_LD_OFF,
    SMCR_LD_COUNT,
    SMCR_LD_LOCKED
  } smcr_lock_e;
endpackage : smcr_pkg

// >>> sim/smcr_regs_monitor.sv
// Port checker for the synthesizer control register bank.
// Bound into smcr_regs; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none

module smcr_regs_monitor #(
  parameter logic [7:0] REVISION_CODE = 8'h5a
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire smcr_pkg::smcr_addr_t REG_ADDR_I,
  input wire smcr_pkg::smcr_byte_t REG_WDATA_I,
  input wire smcr_pkg::smcr_byte_t REG_RDATA_O,
  input wire logic REG_RVALID_O,
  input wire logic [11:0] INT_WORD_O,
  input wire logic ACQ_START_O,
  input wire logic PLL_POWER_DOWN_O,
  input wire logic MODULATOR_POWER_UP_O,
  input wire logic [5:0] ATTEN_DB_O
);
  import smcr_pkg::*;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  logic wr0;
  logic [5:0] atten_map;
  assign wr0 = REG_WR_I && (REG_ADDR_I == 6'h00);
  // Upper codes sit sixteen above their dB value
  assign atten_map = REG_WDATA_I[5] ? REG_WDATA_I[5:0] - 6'h10 : REG_WDATA_I[5:0];

  ////////////////////////////////////////////////////////////////////////
  AST_COMMIT_ACQ: assert property (wr0 |=> ACQ_START_O)
    else $error("no acquisition start after commit");
  AST_ACQ_CAUSE: assert property (ACQ_START_O |-> $past(wr0))
    else $error("acquisition start without commit");
  AST_INT_HOLD: assert property (!$past(wr0) |-> $stable(INT_WORD_O))
    else $error("integer word moved without commit");
  AST_REV_READ: assert property (REG_RD_I && REG_ADDR_I == 6'h21
    |=> REG_RVALID_O && REG_RDATA_O == REVISION_CODE)
    else $error("revision read wrong");
  AST_RVALID_CAUSE: assert property (REG_RVALID_O |-> $past(REG_RD_I))
    else $error("read valid without read");
  AST_PLL_PD: assert property (REG_WR_I && REG_ADDR_I == 6'h0c
    |-> ##2 PLL_POWER_DOWN_O == $past(REG_WDATA_I[2], 2))
    else $error("pll power down not applied");
  AST_MOD_PWR: assert property (REG_WR_I && REG_ADDR_I == 6'h1d
    |-> ##2 MODULATOR_POWER_UP_O == $past(REG_WDATA_I[0], 2))
    else $error("modulator power not applied");
  AST_ATTEN: assert property (REG_WR_I && REG_ADDR_I == 6'h1e && REG_WDATA_I[5:4] != 2'b10
    |-> ##2 ATTEN_DB_O == $past(atten_map, 2))
    else $error("attenuation mapping wrong");
endmodule // smcr_regs_monitor

bind smcr_regs smcr_regs_monitor #(.REVISION_CODE(REVISION_CODE)) u_smcr_regs_monitor (
  .CLK_I, .RESET_N_I, .REG_WR_I, .REG_RD_I, .REG_ADDR_I, .REG_WDATA_I, .REG_RDATA_O,
  .REG_RVALID_O, .INT_WORD_O, .ACQ_START_O, .PLL_POWER_DOWN_O, .MODULATOR_POWER_UP_O,
  .ATTEN_DB_O
);

`default_nettype wire

// >>> sim/smcr_host.sv
// Host model driving the byte register port.
// Assumes the bank answers reads one edge after taking them.
`timescale 1ns/1ps
`default_nettype none

module smcr_host (
  input wire logic clk_i,
  input wire smcr_pkg::smcr_byte_t rdata_i,
  input wire logic rvalid_i,
  output logic wr_o,
  output logic rd_o,
  output smcr_pkg::smcr_addr_t addr_o,
  output smcr_pkg::smcr_byte_t wdata_o
);
  import smcr_pkg::*;
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 6'h00;
    wdata_o = 8'h00;
  end

  task automatic wr(input smcr_addr_t a, input smcr_byte_t d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    // Released lines show the inverse so a stale value never passes
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask

  task automatic rd(input smcr_addr_t a, output smcr_byte_t d, output logic v);
    @(posedge clk_i);
    rd_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    v = rvalid_i;
    d = rdata_i;
  endtask
endmodule // smcr_host

`default_nettype wire

// >>> sim/smcr_regs_bench.sv
// Self-checking bench for the synthesizer control register bank.
// Host model drives the register port; bench drives pins and lock pulses.
`timescale 1ns/1ps
`default_nettype none

module smcr_regs_bench;
  import smcr_pkg::*;
  localparam logic [7:0] REV = 8'hc3;  // Arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tx_off = 1'b0;
  logic lk_p = 1'b0;
  logic lk_w = 1'b1;
  logic [4:0] dv = 5'h00;
  logic wr_s, rd_s, rvalid, acq, t_out, t_oe_n, r_half, r_dbl, pll_pd, lk_det;
  logic a_en, b_en, q_en, d_en, m_en, fine, ac_en, ext, mon, osc_pd, mod;
  smcr_addr_t addr;
  smcr_byte_t wdata, rdata;
  logic [11:0] int_w;
  logic [3:0] cp;
  logic [5:0] rdiv, att;
  logic [1:0] lvl;
  logic [4:0] gate_v;
  logic [8:0] misc_v;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int tg;
  logic pv;
  assign gate_v = {a_en, b_en, q_en, d_en, m_en};
  assign misc_v = {pll_pd, fine, ac_en, ext, mon, lvl, osc_pd, mod};

  always #5 clk = ~clk;
  // Reference and feedback clocks slower than a sixth of the core clock
  always @(posedge clk) dv <= dv + 5'h01;

  smcr_host u_smcr_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .wr_o(wr_s),
    .rd_o(rd_s), .addr_o(addr), .wdata_o(wdata));

  smcr_regs #(.REVISION_CODE(REV)) u_smcr_regs (.CLK_I(clk), .RESET_N_I(rst_n),
    .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .TRANSMIT_OFF_PIN_I(tx_off),
    .REF_CLK_I(dv[2]), .FEEDBACK_COMPARE_CLOCK_I(dv[3]), .LOCK_CMP_PULSE_I(lk_p),
    .LOCK_IN_WINDOW_I(lk_w), .INT_WORD_O(int_w), .CP_CURRENT_O(cp), .REF_HALF_EN_O(r_half),
    .REF_DOUBLE_EN_O(r_dbl), .REF_DIV_RATIO_O(rdiv), .ACQ_START_O(acq), .TEST_OUT_O(t_out),
    .TEST_OUT_OE_N_O(t_oe_n), .PLL_POWER_DOWN_O(pll_pd), .ATTEN_EN_O(a_en),
    .OSC_BUFFER_EN_O(b_en), .QUADRATURE_DIVIDER_EN_O(q_en), .OSC_FREQ_DOUBLER_EN_O(d_en),
    .RF_OUTPUT_MONITOR_EN_O(m_en), .LOCK_FINE_WINDOW_O(fine), .LOCK_DETECT_O(lk_det),
    .AUTOCAL_EN_O(ac_en), .EXT_OSC_SEL_O(ext), .MON_POWER_UP_O(mon), .MON_LEVEL_O(lvl),
    .INT_OSC_POWER_DOWN_O(osc_pd), .MODULATOR_POWER_UP_O(mod), .ATTEN_DB_O(att));

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input smcr_addr_t a, input smcr_byte_t d);
    u_smcr_host.wr(a, d);
  endtask

  task automatic rd_chk(input smcr_addr_t a, input smcr_byte_t e);
    smcr_byte_t d;
    logic v;
    u_smcr_host.rd(a, d, v);
    chk("rvalid", 12'h001, 12'(v));
    chk("rdata", 12'(e), 12'(d));
  endtask

  // Unbuffered fields land two edges after the write edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic pulses(input int n);
    @(posedge clk);
    lk_p <= 1'b1;
    repeat (n) @(posedge clk);
    lk_p <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    smcr_addr_t ua [6] = '{6'h0c, 6'h18, 6'h1b, 6'h1c, 6'h1d, 6'h17};
    smcr_byte_t ud [6] = '{8'h04, 8'h01, 8'h0f, 8'h20, 8'h01, 8'h14};
    logic [8:0] ue [6] = '{9'h140, 9'h100, 9'h13c, 9'h13e, 9'h13f, 9'h1bf};
    smcr_byte_t ac [4] = '{8'h00, 8'h1f, 8'h30, 8'hff};
    logic [5:0] ae [4] = '{6'h00, 6'h1f, 6'h20, 6'h2f};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    settle;
    chk("int word", 12'h000, int_w);
    chk("cp", 12'h000, 12'(cp));
    chk("ref path", 12'h020, 12'({r_half, r_dbl, rdiv}));
    chk("gates", 12'h01f, 12'(gate_v));
    chk("misc", 12'h040, 12'(misc_v));
    chk("lock", 12'h002, 12'({t_oe_n, lk_det}));
    $display("Test reset done");

    wr(6'h06, 8'h3d);
    wr(6'h07, 8'h05);
    wr(6'h09, 8'hf0);
    wr(6'h0a, 8'h3f);
    settle;
    chk("int held", 12'h000, int_w);
    chk("ref held", 12'h020, 12'({r_half, r_dbl, rdiv}));
    wr(6'h00, 8'h00);
    #1;
    chk("acq", 12'h001, 12'(acq));
    chk("int word", 12'h53d, int_w);
    @(posedge clk);
    #1;
    chk("acq end", 12'h000, 12'(acq));
    chk("cp", 12'h00f, 12'(cp));
    chk("ref path", 12'h05f, 12'({r_half, r_dbl, rdiv}));
    wr(6'h0a, 8'h40);
    wr(6'h00, 8'h00);
    settle;
    chk("ref path", 12'h0a0, 12'({r_half, r_dbl, rdiv}));
    rd_chk(6'h07, 8'h05);
    $display("Test commit done");

    for (int i = 0; i < 3; i++) begin
      wr(6'h07, {4'(i), 4'h5});
      settle;
      chk("test pin", 12'(i == 0 ? 2 : i == 1 ? 1 : 0), 12'({t_oe_n, t_out & ~t_oe_n}));
    end
    for (int i = 0; i < 2; i++) begin
      wr(6'h07, {4'hd + 4'(i), 4'h5});
      settle;
      tg = 0;
      repeat (40) begin
        pv = t_out;
        @(posedge clk);
        #1;
        if (t_out !== pv)
          tg++;
      end
      chk("test clock", 12'h001, 12'(tg >= 2 && t_oe_n === 1'b0));
    end
    $display("Test select done");

    foreach (ua[i]) begin
      wr(ua[i], ud[i]);
      settle;
      chk("misc", 12'(ue[i]), 12'(misc_v));
    end
    for (int k = 0; k < 4; k++) begin
      wr(6'h1b, {6'h03, 2'(k)});
      settle;
      chk("mon level", 12'(k), 12'(lvl));
    end
    wr(6'h0c, 8'hff);
    rd_chk(6'h0c, 8'h04);
    foreach (ac[i]) begin
      wr(6'h1e, ac[i]);
      settle;
      chk("atten", 12'(ae[i]), 12'(att));
    end
    $display("Test direct fields done");

    wr(6'h0e, 8'h3b);
    settle;
    chk("gates tx on", 12'h01f, 12'(gate_v));
    @(posedge clk);
    tx_off <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("gates tx off", 12'h000, 12'(gate_v));
    wr(6'h0e, 8'h1b);
    settle;
    chk("gates atten kept", 12'h010, 12'(gate_v));
    rd_chk(6'h21, REV);
    wr(6'h21, 8'h00);
    rd_chk(6'h21, REV);
    rd_chk(6'h3f, 8'h00);
    $display("Test gating and revision done");

    wr(6'h0c, 8'h00);
    wr(6'h17, 8'h1c);
    pulses(2047);
    chk("lock early", 12'h000, 12'(lk_det));
    pulses(1);
    chk("lock short", 12'h001, 12'(lk_det));
    @(posedge clk);
    lk_w <= 1'b0;
    pulses(1);
    chk("lock lost", 12'h000, 12'(lk_det));
    @(posedge clk);
    lk_w <= 1'b1;
    wr(6'h17, 8'h14);
    pulses(3071);
    chk("lock early", 12'h000, 12'(lk_det));
    pulses(1);
    chk("lock long", 12'h001, 12'(lk_det));
    wr(6'h17, 8'h04);
    settle;
    chk("lock off", 12'h000, 12'(lk_det));
    $display("Test lock done");
    test_done;
  end
endmodule // smcr_regs_bench

`default_nettype wire
